// ==== design/angle_jump_event_block.sv ====
// angle-jump stage: pick-up, blocking, trip hold, events, counters, records, APB registers
`timescale 1ns/1ps
`default_nettype none
module angle_jump_event_block #(
	parameter int TRIP_HOLD_CYC = angle_jump_pkg::TRIP_HOLD_CYC,
	parameter int CLK_PER_MS    = angle_jump_pkg::CLK_PER_MS
) (
	// clock and reset
	input  wire logic                                clk,
	input  wire logic                                arst_n,
	// apb slave
	input  wire logic [7:0]                          paddr,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [31:0]                         pwdata,
	output var logic [31:0]                          prdata,
	output var logic                                 pready,
	output var logic                                 pslverr,
	// measurement path and blocking matrix
	input  wire logic                                cycleTick,
	input  wire logic                                sampleTick,
	input  wire angle_jump_pkg::chan_in_s [2:0]      chanIn,
	input  wire logic [2:0]                          chanAvail,
	input  wire logic                                blockIn,
	input  wire logic [2:0]                          settingGroup,
	// stage outputs
	output var logic                                 tripOut,
	output var logic                                 alarmOut,
	output var logic                                 blockedOut,
	output var angle_jump_pkg::cond_e                condition,
	output var logic                                 selOk,
	// event stream
	output var logic                                 evtValid,
	output var angle_jump_pkg::evt_e                 evtCode,
	output var logic [31:0]                          evtStamp
);
	typedef struct packed {
		logic [31:0]                                  prdata;
		logic                                         pready;
		logic                                         pslverr;
		logic                                         tripAndAlarm;
		logic                                         allMode;
		logic [2:0]                                   chanMask;
		logic [15:0]                                  tripSet;
		logic [15:0]                                  alarmSet;
		logic [15:0]                                  uvLimit;
		logic [5:0]                                   evtSel;
		logic [3:0]                                   recSel;
		logic                                         blockSmp;
		logic                                         tripOut;
		logic [18:0]                                  tripTimer;
		logic                                         alarmOut;
		logic                                         blockedOut;
		angle_jump_pkg::cond_e                        cond;
		logic                                         selOk;
		logic [14:0]                                  msPre;
		logic [31:0]                                  msCount;
		logic [5:0]                                   pend;
		logic                                         evtValid;
		angle_jump_pkg::evt_e                         evtCode;
		logic [31:0]                                  evtStamp;
		logic [15:0]                                  cntAlarm;
		logic [15:0]                                  cntTrip;
		logic [15:0]                                  cntBlock;
		angle_jump_pkg::record_s [angle_jump_pkg::NUM_REC-1:0] rec;
		logic [3:0]                                   wrPtr;
		logic [3:0]                                   recCount;
	} state_s;

	state_s                           s_q;
	state_s                           s_d;
	angle_jump_pkg::chan_out_s [2:0]  chanRes;
	logic [2:0][16:0]                 mag;
	logic [2:0]                       tripHit;
	logic [2:0]                       alarmHit;
	logic [2:0]                       uvHit;
	logic [1:0]                       worstCh;
	logic [16:0]                      worstMag;
	logic [16:0]                      worstDiff;
	logic                             pickTrip;
	logic                             pickAlarm;
	logic                             blk;
	logic [5:0]                       newEv;
	logic [5:0]                       taken;
	logic                             found;
	logic [2:0]                       pickIdx;
	logic                             clrReq;
	logic [31:0]                      rdData;
	logic                             hit;
	logic [4:0]                       recIdxW;
	logic [3:0]                       recIdx;
	angle_jump_pkg::record_s          recRd;

	// per-channel measurement units share the undervoltage limit
	for (genvar g = 0; g < angle_jump_pkg::NUM_CH; g++) begin : g_ch
		angle_jump_channel u_ch (
			.clk        (clk),
			.arst_n     (arst_n),
			.sampleTick (sampleTick),
			.meas       (chanIn[g]),
			.uvLimit    (s_q.uvLimit),
			.result     (chanRes[g])
		);
	end

	// record slot for reading, newest first
	always_comb begin
		recIdxW = {1'b0, s_q.wrPtr} + 5'(angle_jump_pkg::NUM_REC - 1) - {1'b0, s_q.recSel};
		if (recIdxW >= 5'(angle_jump_pkg::NUM_REC)) begin
			recIdxW = recIdxW - 5'(angle_jump_pkg::NUM_REC);
		end
		recIdx = recIdxW[3:0];
		recRd = '0;
		if (s_q.recSel < s_q.recCount) begin
			recRd = s_q.rec[recIdx];
		end
	end

	// read decode; unmapped or misaligned addresses answer with an error
	always_comb begin
		rdData = '0;
		hit = 1'b1;
		case (paddr)
			angle_jump_pkg::OFS_CTRL: begin
				rdData[angle_jump_pkg::CTRL_MODE_BIT] = s_q.tripAndAlarm;
				rdData[angle_jump_pkg::CTRL_ALL_BIT] = s_q.allMode;
				rdData[angle_jump_pkg::CTRL_MASK_LSB+:3] = s_q.chanMask;
			end
			angle_jump_pkg::OFS_TRIP_SET:  rdData = {16'h0000, s_q.tripSet};
			angle_jump_pkg::OFS_ALARM_SET: rdData = {16'h0000, s_q.alarmSet};
			angle_jump_pkg::OFS_UV_LIMIT:  rdData = {16'h0000, s_q.uvLimit};
			angle_jump_pkg::OFS_EVT_SEL:   rdData = {26'h0000000, s_q.evtSel};
			angle_jump_pkg::OFS_STATUS: begin
				rdData = {25'h0000000, s_q.blockSmp, s_q.blockedOut, s_q.alarmOut,
					s_q.tripOut, s_q.selOk, s_q.cond};
			end
			angle_jump_pkg::OFS_CNT_ALARM: rdData = {16'h0000, s_q.cntAlarm};
			angle_jump_pkg::OFS_CNT_TRIP:  rdData = {16'h0000, s_q.cntTrip};
			angle_jump_pkg::OFS_CNT_BLOCK: rdData = {16'h0000, s_q.cntBlock};
			angle_jump_pkg::OFS_REC_SEL:   rdData = {28'h0000000, s_q.recSel};
			angle_jump_pkg::OFS_REC_COUNT: rdData = {28'h0000000, s_q.recCount};
			angle_jump_pkg::OFS_REC_STAMP: rdData = recRd.stamp;
			angle_jump_pkg::OFS_REC_INFO: begin
				rdData = {24'h000000, recRd.group, recRd.channel, recRd.evt};
			end
			angle_jump_pkg::OFS_REC_TRIP:  rdData = {{15{recRd.tripDiff[16]}}, recRd.tripDiff};
			angle_jump_pkg::OFS_REC_ALARM: rdData = {{15{recRd.alarmDiff[16]}}, recRd.alarmDiff};
			default: begin
				hit = 1'b0;
				for (int i = 0; i < angle_jump_pkg::NUM_CH; i++) begin
					if (paddr == angle_jump_pkg::OFS_ANGLE0 + 8'(4 * i)) begin
						rdData = {{15{chanRes[i].change[16]}}, chanRes[i].change};
						hit = 1'b1;
					end
					if (paddr == angle_jump_pkg::OFS_RATIO0 + 8'(4 * i)) begin
						rdData = {15'h0000, chanRes[i].ratio};
						hit = 1'b1;
					end
				end
			end
		endcase
	end

	// channel screening; only selected channels take part
	always_comb begin
		tripHit = '0;
		alarmHit = '0;
		uvHit = '0;
		worstCh = 2'h0;
		worstMag = '0;
		for (int i = 0; i < angle_jump_pkg::NUM_CH; i++) begin
			mag[i] = chanRes[i].change[16] ? (~chanRes[i].change + 17'h00001) : chanRes[i].change;
			tripHit[i] = s_q.chanMask[i] & (mag[i] >= {1'b0, s_q.tripSet});
			alarmHit[i] = s_q.chanMask[i] & (mag[i] >= {1'b0, s_q.alarmSet});
			uvHit[i] = s_q.chanMask[i] & chanRes[i].underVolt;
			if (s_q.chanMask[i] && mag[i] > worstMag) begin
				worstMag = mag[i];
				worstCh = 2'(i);
			end
		end
		worstDiff = chanRes[worstCh].change;
		pickTrip = s_q.selOk & (s_q.allMode ? (tripHit == s_q.chanMask) : (tripHit != 3'h0));
		pickAlarm = s_q.tripAndAlarm & s_q.selOk &
			(s_q.allMode ? (alarmHit == s_q.chanMask) : (alarmHit != 3'h0));
		blk = blockIn | (|uvHit);
	end

	// main next-state logic
	always_comb begin
		s_d = s_q;
		clrReq = 1'b0;
		// apb: answer one cycle after setup; writes land at the completing edge
		s_d.pready = 1'b0;
		s_d.pslverr = 1'b0;
		if (psel && !penable) begin
			s_d.pready = 1'b1;
			s_d.prdata = hit ? rdData : 32'h00000000;
			s_d.pslverr = ~hit;
		end
		if (psel && penable && s_q.pready && pwrite && hit) begin
			case (paddr)
				angle_jump_pkg::OFS_CTRL: begin
					s_d.tripAndAlarm = pwdata[angle_jump_pkg::CTRL_MODE_BIT];
					s_d.allMode = pwdata[angle_jump_pkg::CTRL_ALL_BIT];
					s_d.chanMask = pwdata[angle_jump_pkg::CTRL_MASK_LSB+:3];
					clrReq = pwdata[angle_jump_pkg::CTRL_CLR_BIT];
				end
				angle_jump_pkg::OFS_TRIP_SET:  s_d.tripSet = pwdata[15:0];
				angle_jump_pkg::OFS_ALARM_SET: s_d.alarmSet = pwdata[15:0];
				angle_jump_pkg::OFS_UV_LIMIT:  s_d.uvLimit = pwdata[15:0];
				angle_jump_pkg::OFS_EVT_SEL:   s_d.evtSel = pwdata[5:0];
				angle_jump_pkg::OFS_REC_SEL:   s_d.recSel = pwdata[3:0];
				default: ;
			endcase
		end
		// selection is valid only if some channel is chosen and all chosen are present
		s_d.selOk = (s_q.chanMask != 3'h0) && ((s_q.chanMask & ~chanAvail) == 3'h0);
		// millisecond time base for stamps
		if (s_q.msPre == 15'(CLK_PER_MS - 1)) begin
			s_d.msPre = '0;
			s_d.msCount = s_q.msCount + 32'h00000001;
		end else begin
			s_d.msPre = s_q.msPre + 15'h0001;
		end
		// trip hold runs on clocks, independent of the program cycle
		if (s_q.tripOut) begin
			if (s_q.tripTimer == 19'h00000) begin
				s_d.tripOut = 1'b0;
			end else begin
				s_d.tripTimer = s_q.tripTimer - 19'h00001;
			end
		end
		// evaluation once per program cycle with the block level taken at its start
		if (cycleTick) begin
			s_d.blockSmp = blockIn;
			s_d.blockedOut = (pickTrip | pickAlarm) & blk;
			s_d.alarmOut = pickAlarm & ~blk;
			if (pickTrip && !blk && !s_q.tripOut) begin
				s_d.tripOut = 1'b1;
				s_d.tripTimer = 19'(TRIP_HOLD_CYC - 1);
			end
		end
		// trip outranks alarm, alarm outranks blocked
		if (s_d.tripOut) begin
			s_d.cond = angle_jump_pkg::COND_TRIP;
		end else if (s_d.alarmOut) begin
			s_d.cond = angle_jump_pkg::COND_ALARM;
		end else if (s_d.blockedOut) begin
			s_d.cond = angle_jump_pkg::COND_BLOCKED;
		end else begin
			s_d.cond = angle_jump_pkg::COND_NORMAL;
		end
		// edges of the three outputs become pending events, bit index is the event code
		newEv = {s_q.alarmOut & ~s_d.alarmOut, ~s_q.alarmOut & s_d.alarmOut,
			s_q.tripOut & ~s_d.tripOut, ~s_q.tripOut & s_d.tripOut,
			s_q.blockedOut & ~s_d.blockedOut, ~s_q.blockedOut & s_d.blockedOut};
		// one event leaves per clock, lowest code first, so no edge is dropped
		found = 1'b0;
		pickIdx = 3'h0;
		for (int i = 0; i < angle_jump_pkg::NUM_EVT; i++) begin
			if (!found && s_q.pend[i]) begin
				found = 1'b1;
				pickIdx = 3'(i);
			end
		end
		taken = found ? (6'h01 << pickIdx) : 6'h00;
		s_d.evtValid = found & s_q.evtSel[pickIdx];
		if (found) begin
			s_d.evtCode = angle_jump_pkg::evt_e'(pickIdx);
			s_d.evtStamp = s_q.msCount;
		end
		// a new edge in the same cycle as its removal stays pending
		s_d.pend = (s_q.pend & ~taken) | newEv;
		// records on ON events only; the ring overwrites the oldest slot when full
		if (found && !pickIdx[0]) begin
			s_d.rec[s_q.wrPtr].stamp = s_q.msCount;
			s_d.rec[s_q.wrPtr].evt = angle_jump_pkg::evt_e'(pickIdx);
			s_d.rec[s_q.wrPtr].channel = worstCh;
			s_d.rec[s_q.wrPtr].tripDiff = (pickIdx == angle_jump_pkg::EVT_TRIP_ON) ? worstDiff : 17'h00000;
			s_d.rec[s_q.wrPtr].alarmDiff = (pickIdx == angle_jump_pkg::EVT_ALARM_ON) ? worstDiff : 17'h00000;
			s_d.rec[s_q.wrPtr].group = settingGroup;
			if (s_q.wrPtr == 4'(angle_jump_pkg::NUM_REC - 1)) begin
				s_d.wrPtr = 4'h0;
			end else begin
				s_d.wrPtr = s_q.wrPtr + 4'h1;
			end
			if (s_q.recCount != 4'(angle_jump_pkg::NUM_REC)) begin
				s_d.recCount = s_q.recCount + 4'h1;
			end
		end
		// counters: clear first so a simultaneous occurrence still counts
		if (clrReq) begin
			s_d.cntAlarm = '0;
			s_d.cntTrip = '0;
			s_d.cntBlock = '0;
		end
		if (newEv[angle_jump_pkg::EVT_ALARM_ON]) begin
			s_d.cntAlarm = s_d.cntAlarm + 16'h0001;
		end
		if (newEv[angle_jump_pkg::EVT_TRIP_ON]) begin
			s_d.cntTrip = s_d.cntTrip + 16'h0001;
		end
		if (newEv[angle_jump_pkg::EVT_BLOCK_ON]) begin
			s_d.cntBlock = s_d.cntBlock + 16'h0001;
		end
	end

	// state register with documented defaults
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
			s_q.chanMask <= angle_jump_pkg::RST_MASK;
			s_q.tripSet <= angle_jump_pkg::RST_TRIP_SET;
			s_q.alarmSet <= angle_jump_pkg::RST_ALARM_SET;
			s_q.uvLimit <= angle_jump_pkg::RST_UV_LIMIT;
			s_q.evtSel <= angle_jump_pkg::RST_EVT_SEL;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign tripOut = s_q.tripOut;
	assign alarmOut = s_q.alarmOut;
	assign blockedOut = s_q.blockedOut;
	assign condition = s_q.cond;
	assign selOk = s_q.selOk;
	assign evtValid = s_q.evtValid;
	assign evtCode = s_q.evtCode;
	assign evtStamp = s_q.evtStamp;
endmodule
`default_nettype wire

// ==== shared/angle_jump_pkg.sv ====
// package: constants, register map and carrier types of the angle-jump stage
// Contract
// - stage condition output shows one of normal, blocked, trip, alarm
// - a flag shows whether the monitored channel selection is available
// - per channel, signed angle change against 20 ms earlier, 0.01 deg steps
// - per channel, measured voltage over undervoltage limit, 0.01 p.u. steps
// - blocking input is sampled at the start of every program cycle
// - pick-up without blocking raises trip or alarm and starts timing
// - pick-up under blocking raises blocked and nothing else
// - block, trip, alarm ON/OFF events are time-stamped and selectable per event
// - alarm, trip and blocked occurrences are counted, clearable on request
// - the last twelve time-stamped operation records are kept
// - records taken on ON events only, with stamp, event, channel, angles, group
// - trip output holds 20 ms then releases by itself
// - stage is blocked while measured voltage is below the undervoltage limit
// - option selects trip only or trip and alarm, trip only after reset
package angle_jump_pkg;
	// timing
	localparam int CLK_HZ        = 25000000;
	localparam int MS_PER_S      = 1000;
	localparam int CLK_PER_MS    = CLK_HZ / MS_PER_S;
	localparam int TRIP_HOLD_MS  = 20;
	localparam int TRIP_HOLD_CYC = CLK_PER_MS * TRIP_HOLD_MS;
	localparam int HIST_MS       = 20;
	localparam int SAMPLE_MS     = 5;
	localparam int HIST_DEPTH    = HIST_MS / SAMPLE_MS;
	// sizes and scaling
	localparam int NUM_CH  = 3;
	localparam int NUM_REC = 12;
	localparam int NUM_EVT = 6;
	localparam int DIV_STEPS = 23;
	localparam logic signed [17:0] DEG_HALF  = 18'sh04650;
	localparam logic signed [17:0] DEG_FULL  = 18'sh08ca0;
	localparam logic [22:0]        RATIO_MAX = 23'h008ca0;
	localparam logic [22:0]        PU_SCALE  = 23'h000064;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_TRIP_SET  = 8'h04;
	localparam logic [7:0] OFS_ALARM_SET = 8'h08;
	localparam logic [7:0] OFS_UV_LIMIT  = 8'h0c;
	localparam logic [7:0] OFS_EVT_SEL   = 8'h10;
	localparam logic [7:0] OFS_STATUS    = 8'h14;
	localparam logic [7:0] OFS_CNT_ALARM = 8'h18;
	localparam logic [7:0] OFS_CNT_TRIP  = 8'h1c;
	localparam logic [7:0] OFS_CNT_BLOCK = 8'h20;
	localparam logic [7:0] OFS_ANGLE0    = 8'h24;
	localparam logic [7:0] OFS_RATIO0    = 8'h30;
	localparam logic [7:0] OFS_REC_SEL   = 8'h3c;
	localparam logic [7:0] OFS_REC_COUNT = 8'h40;
	localparam logic [7:0] OFS_REC_STAMP = 8'h44;
	localparam logic [7:0] OFS_REC_INFO  = 8'h48;
	localparam logic [7:0] OFS_REC_TRIP  = 8'h4c;
	localparam logic [7:0] OFS_REC_ALARM = 8'h50;
	// control field positions
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_CLR_BIT  = 1;
	localparam int CTRL_ALL_BIT  = 2;
	localparam int CTRL_MASK_LSB = 4;
	// reset values
	localparam logic [2:0]  RST_MASK      = 3'h7;
	localparam logic [15:0] RST_TRIP_SET  = 16'h01f4;
	localparam logic [15:0] RST_ALARM_SET = 16'h01f4;
	localparam logic [15:0] RST_UV_LIMIT  = 16'h251c;
	localparam logic [5:0]  RST_EVT_SEL   = 6'h3f;
	// types
	typedef enum logic [1:0] {COND_NORMAL, COND_BLOCKED, COND_TRIP, COND_ALARM} cond_e;
	typedef enum logic [2:0] {EVT_BLOCK_ON, EVT_BLOCK_OFF, EVT_TRIP_ON, EVT_TRIP_OFF,
		EVT_ALARM_ON, EVT_ALARM_OFF} evt_e;
	typedef struct packed {
		logic [15:0] angle;
		logic [15:0] volt;
	} chan_in_s;
	typedef struct packed {
		logic signed [16:0] change;
		logic [16:0]        ratio;
		logic               underVolt;
	} chan_out_s;
	typedef struct packed {
		logic [31:0] stamp;
		evt_e        evt;
		logic [1:0]  channel;
		logic [16:0] tripDiff;
		logic [16:0] alarmDiff;
		logic [2:0]  group;
	} record_s;
endpackage

// ==== design/angle_jump_channel.sv ====
// one voltage channel: 20 ms angle change and voltage-to-limit ratio
`timescale 1ns/1ps
`default_nettype none
module angle_jump_channel (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     arst_n,
	// measurement
	input  wire logic                     sampleTick,
	input  wire angle_jump_pkg::chan_in_s meas,
	input  wire logic [15:0]              uvLimit,
	// results
	output var angle_jump_pkg::chan_out_s result
);
	typedef struct packed {
		logic [angle_jump_pkg::HIST_DEPTH-1:0][15:0] hist;
		logic [22:0]                              dividend;
		logic [22:0]                              rem;
		logic [22:0]                              quot;
		logic [4:0]                               step;
		logic                                     busy;
		angle_jump_pkg::chan_out_s                res;
	} state_s;
	state_s            s_q;
	state_s            s_d;
	logic signed [17:0] delta;
	logic [22:0]        remShift;
	logic [22:0]        quotNext;

	// angle history and serial divider; restoring division keeps area small, 23 clocks per sample
	always_comb begin
		s_d = s_q;
		delta = $signed({2'b00, meas.angle}) - $signed({2'b00, s_q.hist[angle_jump_pkg::HIST_DEPTH-1]});
		if (delta > angle_jump_pkg::DEG_HALF) begin
			delta = delta - angle_jump_pkg::DEG_FULL; // wrap across 360 deg
		end else if (delta < -angle_jump_pkg::DEG_HALF) begin
			delta = delta + angle_jump_pkg::DEG_FULL;
		end
		remShift = {s_q.rem[21:0], s_q.dividend[22]};
		quotNext = {s_q.quot[21:0], 1'b0};
		if (remShift >= {7'h00, uvLimit}) begin
			remShift = remShift - {7'h00, uvLimit};
			quotNext = {s_q.quot[21:0], 1'b1};
		end
		if (sampleTick) begin
			s_d.hist = {s_q.hist[angle_jump_pkg::HIST_DEPTH-2:0], meas.angle};
			s_d.res.change = delta[16:0];
			s_d.res.underVolt = meas.volt < uvLimit;
			s_d.dividend = {7'h00, meas.volt} * angle_jump_pkg::PU_SCALE;
			s_d.rem = '0;
			s_d.quot = '0;
			s_d.step = '0;
			s_d.busy = 1'b1;
		end else if (s_q.busy) begin
			s_d.dividend = {s_q.dividend[21:0], 1'b0};
			s_d.rem = remShift;
			s_d.quot = quotNext;
			s_d.step = s_q.step + 5'h01;
			if (s_q.step == 5'(angle_jump_pkg::DIV_STEPS - 1)) begin
				s_d.busy = 1'b0;
				// saturate; a zero limit also ends here
				s_d.res.ratio = (quotNext > angle_jump_pkg::RATIO_MAX) ?
					angle_jump_pkg::RATIO_MAX[16:0] : quotNext[16:0];
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign result = s_q.res;
endmodule
`default_nettype wire

// ==== testbench/angle_jump_event_block_checker.sv ====
// checker: timing relations at the angle-jump stage ports
`timescale 1ns/1ps
`default_nettype none
module angle_jump_event_block_checker #(parameter int TRIP_HOLD_CYC = 20) (
	// clock, reset, bus handshake
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// stage outputs and their cause
	input wire logic cycleTick,
	input wire logic tripOut,
	input wire logic alarmOut,
	input wire logic blockedOut,
	input wire angle_jump_pkg::cond_e condition,
	input wire logic evtValid,
	input wire angle_jump_pkg::evt_e evtCode
);
	logic [19:0] hiCnt_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// trip run length; a retrigger would stretch it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) hiCnt_q <= 20'h00000;
		else hiCnt_q <= tripOut ? hiCnt_q + 20'h00001 : 20'h00000;
	end
	sequence s_tripFall; $fell(tripOut); endsequence
	sequence s_offEvt; evtValid && evtCode == angle_jump_pkg::EVT_TRIP_OFF; endsequence
	property p_tripHold; s_tripFall |-> hiCnt_q == TRIP_HOLD_CYC; endproperty
	a_tripHold: assert property (p_tripHold) else $error("trip hold wrong");
	property p_tripLen; tripOut |-> hiCnt_q < TRIP_HOLD_CYC; endproperty
	a_tripLen: assert property (p_tripLen) else $error("trip held too long");
	property p_tripOffEvt; s_tripFall |-> ##[1:6] s_offEvt; endproperty
	a_tripOffEvt: assert property (p_tripOffEvt) else $error("trip off event missing");
	property p_tripOnEvt; evtValid && evtCode == angle_jump_pkg::EVT_TRIP_ON |-> tripOut; endproperty
	a_tripOnEvt: assert property (p_tripOnEvt) else $error("trip on event, no trip");
	property p_condTrip; tripOut |-> condition == angle_jump_pkg::COND_TRIP; endproperty
	a_condTrip: assert property (p_condTrip) else $error("condition not trip");
	property p_outTiming; $changed({alarmOut, blockedOut}) |-> $past(cycleTick); endproperty
	a_outTiming: assert property (p_outTiming) else $error("output moved off a cycle");
	property p_alarmFree; alarmOut |-> !blockedOut; endproperty
	a_alarmFree: assert property (p_alarmFree) else $error("alarm under block");
	property p_apbAnswer; psel && !penable |=> pready ##1 !pready; endproperty
	a_apbAnswer: assert property (p_apbAnswer) else $error("bus answer wrong");
endmodule
bind angle_jump_event_block angle_jump_event_block_checker #(.TRIP_HOLD_CYC(TRIP_HOLD_CYC))
	angle_jump_event_block_checker_inst (.clk, .arst_n, .psel, .penable, .pready, .cycleTick, .tripOut,
	.alarmOut, .blockedOut, .condition, .evtValid, .evtCode);
`default_nettype wire

// ==== testbench/angle_jump_source_model.sv ====
// model of the measurement path and blocking matrix
`timescale 1ns/1ps
`default_nettype none
module angle_jump_source_model #(parameter int SAMPLE_CLK = 50) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// scenario controls
	input wire logic [15:0] stepSet,
	input wire logic [15:0] voltSet,
	input wire logic blockSet,
	input wire logic cycleReq,
	// toward the stage
	output logic sampleTick,
	output wire logic cycleTick,
	output var angle_jump_pkg::chan_in_s [2:0] chanIn,
	output logic blockIn
);
	logic [7:0] cnt_q;
	logic [16:0] phase_q;
	logic [16:0] nextPhase;
	assign cycleTick = cycleReq;
	assign nextPhase = phase_q + {1'b0, stepSet};
	// only channel 0 turns, so it is the faulted one
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 8'h00;
			phase_q <= 17'h00000;
			sampleTick <= 1'b0;
			chanIn <= '0;
			blockIn <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == 8'(SAMPLE_CLK - 1)) ? 8'h00 : cnt_q + 8'h01;
			sampleTick <= (cnt_q == 8'h00);
			blockIn <= blockSet; // one clock, far ahead of any operate delay
			// change mid-period, steady at the next sample
			if (cnt_q == 8'h19) begin
				phase_q <= (nextPhase >= 17'h08ca0) ? nextPhase - 17'h08ca0 : nextPhase;
				chanIn <= {16'h0000, voltSet, 16'h0000, voltSet, phase_q[15:0], voltSet};
			end
		end
	end
endmodule
`default_nettype wire

// ==== testbench/angle_jump_event_block_tb.sv ====
// self-checking bench for the angle-jump stage
`timescale 1ns/1ps
`default_nettype none
module angle_jump_event_block_tb;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic blockSet = 1'b0;
	logic cycleReq = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic [15:0] stepSet = 16'h0000, voltSet = 16'h2710;
	logic [2:0] chanAvail = 3'h7;
	logic pready, pslverr, errSeen, sampleTick, cycleTick, blockIn, tripOut, alarmOut, blockedOut, selOk, evtValid;
	angle_jump_pkg::chan_in_s [2:0] chanIn;
	angle_jump_pkg::cond_e condition;
	angle_jump_pkg::evt_e evtCode;
	wire [31:0] outs = {27'h0, tripOut, alarmOut, blockedOut, condition};
	int fail_count = 0;
	int check_count = 0;
	// 25 MHz clock
	always #20 clk = ~clk;
	// far side
	angle_jump_source_model angle_jump_source_model_inst (.clk, .arst_n, .stepSet, .voltSet, .blockSet,
		.cycleReq, .sampleTick, .cycleTick, .chanIn, .blockIn);
	// short trip hold keeps the run brief
	angle_jump_event_block #(.TRIP_HOLD_CYC(20), .CLK_PER_MS(10)) angle_jump_event_block_inst (.clk, .arst_n,
		.paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .cycleTick, .sampleTick, .chanIn,
		.chanAvail, .blockIn, .settingGroup(3'h2), .tripOut, .alarmOut, .blockedOut, .condition, .selOk,
		.evtValid, .evtCode, .evtStamp());
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask
	// setup, then access held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rdat);
	endtask
	// one program cycle, outputs settled at return
	task automatic cyc;
		@(posedge clk) cycleReq <= 1'b1;
		@(posedge clk) cycleReq <= 1'b0;
		@(negedge clk);
	endtask
	task automatic t_resetValues;
		logic [7:0] a [4] = '{8'h00, 8'h04, 8'h0c, 8'h10};
		logic [31:0] e [4] = '{32'h70, 32'h1f4, 32'h251c, 32'h3f};
		for (int i = 0; i < 4; i++) rdc(a[i], e[i], "reset value");
		apb(1'b0, 8'h54, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, errSeen});
	endtask
	// steady 10 degree jumps on channel 0
	task automatic t_trip;
		@(posedge clk) stepSet <= 16'h00fa;
		repeat (320) @(posedge clk);
		cyc();
		chk("trip outputs", 32'h12, outs);
		repeat (25) @(posedge clk);
		chk("trip release", 32'h0, {31'h0, tripOut});
		rdc(8'h24, 32'h3e8, "angle change");
		rdc(8'h30, 32'h69, "ratio");
	endtask
	task automatic t_block;
		@(posedge clk) blockSet <= 1'b1;
		cyc();
		chk("blocked outputs", 32'h5, outs);
		@(posedge clk) blockSet <= 1'b0;
		@(posedge clk) voltSet <= 16'h2328;
		repeat (110) @(posedge clk);
		cyc();
		chk("undervoltage outputs", 32'h5, outs);
		rdc(8'h30, 32'h5e, "low ratio");
		@(posedge clk) voltSet <= 16'h2710;
		repeat (80) @(posedge clk);
	endtask
	task automatic t_alarm;
		apb(1'b1, 8'h00, 32'h71);
		cyc();
		chk("alarm outputs", 32'h1a, outs);
		repeat (25) @(posedge clk);
		rdc(8'h18, 32'h1, "alarm count");
		rdc(8'h1c, 32'h2, "trip count");
		rdc(8'h20, 32'h1, "blocked count");
		rdc(8'h40, 32'h4, "record count");
		rdc(8'h48, 32'h44, "newest record");
		apb(1'b1, 8'h00, 32'h73);
		rdc(8'h1c, 32'h0, "cleared count");
	endtask
	// thirteen records into twelve slots
	task automatic t_ring;
		for (int i = 0; i < 3; i++) begin
			@(posedge clk) blockSet <= 1'b1;
			cyc();
			@(posedge clk) blockSet <= 1'b0;
			cyc();
			repeat (25) @(posedge clk);
		end
		rdc(8'h40, 32'hc, "full record count");
		apb(1'b1, 8'h3c, 32'hb);
		rdc(8'h48, 32'h40, "oldest record");
		apb(1'b1, 8'h3c, 32'hc);
		rdc(8'h48, 32'h0, "record past count");
	endtask
	task automatic t_sel;
		@(posedge clk) chanAvail <= 3'h0;
		cyc();
		chk("no selection", 32'h0, {selOk, tripOut, alarmOut});
		@(posedge clk) chanAvail <= 3'h7;
		repeat (2) @(negedge clk);
		chk("selection ok", 32'h1, {31'h0, selOk});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// reset, then scenarios in turn
	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		t_resetValues();
		t_trip();
		t_block();
		t_alarm();
		t_ring();
		t_sel();
		tally_and_finish();
	end
	// watchdog, well past the expected run
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
